// ---- core/apm_core.sv ----
// Purpose: power state, start bit, conversion sequencing and result readout
// Assumes: pins are asynchronous to clk_in and are sampled through two flip-flops
// Notes: the three-level shutdown pin arrives as two decoded digital inputs
`include "apm_regs.svh"

// ------------------------------------------------------------
// result buffer
// ------------------------------------------------------------
module apm_fifo #(
  parameter int WIDTH = `APM_RESULT_W,
  parameter int DEPTH = `APM_FIFO_DEPTH
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH]; // storage words
  logic [AW-1:0] wr_ptr; // next write slot
  logic [AW-1:0] rd_ptr; // next read slot
  logic [AW:0] count; // words held
  logic push;
  logic pop;

  assign in_ready_out = (count != (AW+1)'(DEPTH));
  assign out_valid_out = (count != '0);
  assign out_data_out = mem[rd_ptr];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  // storage write
  always_ff @(posedge clk_in)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// Summary of operation
// - power-up enters internal clock mode
// - strobe high at power-up; first one starts
// - zeros shift out before first conversion
// - power-down chosen by select bit when enabled
// - low shutdown forces shutdown, overrides select
// - software power-down waits for conversion end
// - readout stays alive in software power-down
// - start bit wakes from software power-down
// - select one stays powered, zero sleeps
// - hard shutdown aborts running conversion
// - shutdown level decodes enable and reference
// - result is plain binary, 256 codes
// - clock-mode bit picks conversion clock source
// - first high after chip select is start
// - result MSB first on falling serial clock
module apm_core #(
  parameter int CONV_CYCLES = `APM_CONV_TIME_NS / `APM_CLK_PERIOD_NS
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic cs_n_in,
  input wire logic sclk_in,
  input wire logic din_in,
  input wire logic shutdown_input_n_in,
  input wire logic shutdown_float_in,
  input wire logic [7:0] conversion_code_in,
  output logic dout_out,
  output logic dout_oe_out,
  output logic conversion_done_strobe_out,
  output logic conversion_done_strobe_oe_out,
  output apm_pkg::apm_status_t status_out
);
  import apm_pkg::*;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [4:0] pin_meta; // first stage, read only by second stage
  logic [4:0] pin_sync; // second stage
  logic sclk_prev; // previous synced serial clock
  logic cs_n; // synced chip select
  logic din; // synced data in
  logic shutdown_input_n_low; // shutdown pin driven low
  logic shutdown_input_n_float; // shutdown pin left open
  logic sclk_rise;
  logic sclk_fall;

  // two flip-flops on every pin
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pin_meta <= 5'h19; // serial clock bit at its idle low, so no false rise after reset
      pin_sync <= 5'h19;
      sclk_prev <= 1'h0;
    end
    else
    begin
      pin_meta <= {shutdown_float_in, shutdown_input_n_in, din_in, sclk_in, cs_n_in};
      pin_sync <= pin_meta;
      sclk_prev <= pin_sync[1];
    end
  end

  assign cs_n = pin_sync[0];
  assign din = pin_sync[2];
  assign shutdown_input_n_low = !pin_sync[3];
  assign shutdown_input_n_float = pin_sync[4];
  assign sclk_rise = pin_sync[1] && !sclk_prev;
  assign sclk_fall = !pin_sync[1] && sclk_prev;

  // ------------------------------------------------------------
  // control sequencing
  // ------------------------------------------------------------
  apm_state_t state; // power and conversion state
  apm_ctrl_t ctrl; // latched control byte
  logic [6:0] rx_shift; // bits after the start bit
  logic [2:0] rx_count; // bits still to receive
  logic [12:0] conv_count; // internal conversion timer
  logic [3:0] ext_falls; // serial clock falls in external conversion
  logic clk_mode; // current conversion clock source
  logic [7:0] result; // captured code
  logic fifo_ready;
  logic fifo_valid;
  logic [7:0] fifo_data;
  logic pop;
  logic started; // start bit seen on this edge

  assign started = !cs_n && sclk_rise && din;

  // main state machine
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state <= ST_OFF;
    end
    else if (shutdown_input_n_low)
    begin
      state <= ST_OFF; // abort anything at once
    end
    else
    begin
      case (state)
        ST_OFF:
        begin
          state <= ST_IDLE;
        end
        ST_IDLE, ST_SLEEP:
        begin
          if (started)
          begin
            state <= ST_RX;
          end
        end
        ST_RX:
        begin
          if (cs_n)
          begin
            state <= ST_IDLE;
          end
          else if (sclk_rise && rx_count == 3'h1)
          begin
            state <= ST_CONV;
          end
        end
        ST_CONV:
        begin
          if (clk_mode == `APM_CLK_MODE_INT)
          begin
            if (conv_count == 13'(CONV_CYCLES - 1))
            begin
              state <= ST_STORE;
            end
          end
          else if (cs_n)
          begin
            state <= ST_IDLE;
          end
          else if (sclk_fall && ext_falls == `APM_EXT_CONV_FALLS - 4'h1)
          begin
            state <= ST_STORE;
          end
        end
        ST_STORE:
        begin
          if (fifo_ready)
          begin
            state <= ctrl.power_down_select_bit ? ST_IDLE : ST_SLEEP;
          end
        end
        default:
        begin
          state <= ST_OFF;
        end
      endcase
    end
  end

  // control byte reception
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rx_shift <= 7'h00;
      rx_count <= 3'h0;
      ctrl <= '0;
      clk_mode <= `APM_CLK_MODE_INT;
    end
    else if ((state == ST_IDLE || state == ST_SLEEP) && started)
    begin
      rx_count <= `APM_CTRL_BITS_AFTER_START;
    end
    else if (state == ST_RX && sclk_rise)
    begin
      rx_shift <= {rx_shift[5:0], din};
      rx_count <= rx_count - 3'h1;
      if (rx_count == 3'h1)
      begin
        ctrl <= apm_ctrl_t'({1'b1, rx_shift[5:0], din});
        clk_mode <= din;
      end
    end
  end

  // conversion timing in either clock mode
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      conv_count <= 13'h0000;
      ext_falls <= 4'h0;
      result <= 8'h00;
    end
    else if (state != ST_CONV)
    begin
      conv_count <= 13'h0000;
      ext_falls <= 4'h0;
    end
    else
    begin
      conv_count <= conv_count + 13'h0001;
      if (sclk_fall)
      begin
        ext_falls <= ext_falls + 4'h1;
      end
      result <= conversion_code_in; // straight binary code
    end
  end

  // ------------------------------------------------------------
  // result path
  // ------------------------------------------------------------
  apm_fifo #(
    .WIDTH(`APM_RESULT_W),
    .DEPTH(`APM_FIFO_DEPTH)
  ) u_fifo (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .in_valid_in(state == ST_STORE && !shutdown_input_n_low),
    .in_ready_out(fifo_ready),
    .in_data_in(result),
    .out_valid_out(fifo_valid),
    .out_ready_in(pop),
    .out_data_out(fifo_data)
  );

  logic [8:0] out_shift; // leading zero then result bits
  logic [3:0] out_left; // bits not yet shifted
  assign pop = fifo_valid && (out_left == 4'h0);

  // readout shifter, also runs in software power-down
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      out_shift <= `APM_SHREG_RESET; // zeros until a result
      out_left <= 4'h0;
      dout_out <= 1'h0;
    end
    else if (pop)
    begin
      out_shift <= {1'b0, fifo_data};
      out_left <= 4'h9;
    end
    else if (sclk_fall && !cs_n)
    begin
      dout_out <= out_shift[8]; // MSB first
      out_shift <= {out_shift[7:0], 1'b0};
      out_left <= (out_left == 4'h0) ? 4'h0 : out_left - 4'h1;
    end
  end

  // ------------------------------------------------------------
  // strobe, enables and status
  // ------------------------------------------------------------
  // strobe low while converting internally, brief high in external mode
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      conversion_done_strobe_out <= 1'h1;
      conversion_done_strobe_oe_out <= 1'h1;
      dout_oe_out <= 1'h0;
      status_out <= '0;
    end
    else
    begin
      if (state == ST_CONV)
      begin
        conversion_done_strobe_out <= (clk_mode != `APM_CLK_MODE_INT) && (ext_falls < `APM_STRB_EXT_FALLS);
      end
      else
      begin
        conversion_done_strobe_out <= 1'h1;
      end
      conversion_done_strobe_oe_out <= (clk_mode == `APM_CLK_MODE_INT) || !cs_n;
      dout_oe_out <= !cs_n;
      status_out.converter_enable <= !shutdown_input_n_low;
      status_out.ref_enable <= !shutdown_input_n_low && shutdown_input_n_float;
      status_out.powered <= (state != ST_OFF) && (state != ST_SLEEP);
      status_out.converting <= (state == ST_CONV);
    end
  end
endmodule

// ---- core/apm_regs.svh ----
// Purpose: named constants for the converter power and start-up control
// Assumes: 200 MHz core clock
// Notes: definitions only
`ifndef APM_REGS_SVH
`define APM_REGS_SVH
// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define APM_CLK_PERIOD_NS 5
`define APM_CONV_TIME_NS 25000
`define APM_STRB_EXT_FALLS 4'h2
`define APM_EXT_CONV_FALLS 4'h8
// ------------------------------------------------------------
// control byte fields and counts
// ------------------------------------------------------------
`define APM_CTRL_BITS_AFTER_START 3'h7
`define APM_RESULT_W 8
`define APM_FIFO_DEPTH 8
`define APM_CLK_MODE_INT 1'h0
`define APM_SHREG_RESET 9'h000
`endif

// ---- core/apm_pkg.sv ----
// Purpose: shared types for the converter power and start-up control
// Assumes: apm_regs.svh supplies the numeric constants
// Notes: types only
package apm_pkg;
  // control byte as shifted in, start bit first
  typedef struct packed {
    logic start;
    logic [2:0] channel;
    logic unipolar;
    logic single_ended;
    logic power_down_select_bit;
    logic clock_mode_select_bit;
  } apm_ctrl_t;
  // status flags leaving the block
  typedef struct packed {
    logic converter_enable;
    logic ref_enable;
    logic powered;
    logic converting;
  } apm_status_t;
  // control states
  typedef enum logic [2:0] {
    ST_OFF,
    ST_IDLE,
    ST_RX,
    ST_CONV,
    ST_STORE,
    ST_SLEEP
  } apm_state_t;
endpackage

// ---- tb/apm_assertions.sv ----
// Purpose: pin checks for apm_core
// Assumes: pins reach the state through a 2-FF sync
// Notes: bound below
module apm_chk (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic cs_n_in,
  input wire logic shutdown_input_n_in,
  input wire logic shutdown_float_in,
  input wire logic dout_out,
  input wire logic conversion_done_strobe_out,
  input wire logic conversion_done_strobe_oe_out,
  input wire apm_pkg::apm_status_t status_out
);
  import apm_pkg::*;
  logic seen_conv; // a conversion has begun
  // ----------------------------------------
  // helper
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
      seen_conv <= 1'b0;
    else if (status_out.converting)
      seen_conv <= 1'b1;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // ----------------------------------------
  // rules
  // ----------------------------------------
  a_shutdown_input_n_forces_off: assert property (!shutdown_input_n_in [*5] |-> !status_out.powered)
    else $error("powered while shut down");
  a_shutdown_input_n_aborts_conv: assert property ($fell(shutdown_input_n_in) |-> ##[1:4] !status_out.converting)
    else $error("conversion not aborted");
  a_float_ref_on: assert property ((shutdown_input_n_in && shutdown_float_in) [*4]
    |-> status_out.ref_enable && status_out.converter_enable)
    else $error("open pin decode wrong");
  a_driven_ref_off: assert property (!shutdown_float_in [*4] |-> !status_out.ref_enable)
    else $error("reference on while driven");
  a_off_no_enable: assert property (!shutdown_input_n_in [*4] |-> !status_out.converter_enable)
    else $error("enabled while low");
  a_zero_before: assert property (!seen_conv |-> !dout_out)
    else $error("data before first conversion");
  a_boot_internal: assert property (!seen_conv |-> conversion_done_strobe_oe_out)
    else $error("strobe released before first conversion");
  a_boot_strobe: assert property ($fell(rst_in) |-> conversion_done_strobe_out)
    else $error("strobe low after reset");
  a_conv_powered: assert property (status_out.converting |-> status_out.powered)
    else $error("converting while powered down");
  a_dout_idle: assert property (cs_n_in [*4] |-> !seen_conv || $stable(dout_out))
    else $error("data moved while deselected");
  c_conv: cover property ($rose(status_out.converting));
  c_sleep: cover property ($fell(status_out.powered));
  c_data: cover property ($rose(dout_out));
endmodule
bind apm_core apm_chk apm_chk_inst (.clk_in, .rst_in, .cs_n_in, .shutdown_input_n_in,
  .shutdown_float_in, .dout_out, .conversion_done_strobe_out, .conversion_done_strobe_oe_out, .status_out);

// ---- tb/apm_host.sv ----
// Purpose: serial master driving the link
// Assumes: clock idles low, data taken on rise
// Notes: 64 ns link period
module apm_host (
  output logic cs_n_out,
  output logic sclk_out,
  output logic din_out,
  input wire logic dout_in
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    din_out = 1'b0;
  end
  // select or release the device
  task automatic sel(input logic s);
    cs_n_out = !s;
    #24;
  endtask
  // eight bits each way, msb first
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      din_out = tx[i]; // first one is the start bit
      #32 sclk_out = 1'b1;
      rx[i] = dout_in; // data moved on the fall before
      #32 sclk_out = 1'b0;
    end
    din_out = 1'b0;
  endtask
endmodule

// ---- tb/tb_top.sv ----
// Purpose: directed tests for apm_core
// Assumes: short conversion count
// Notes: ends through end_sim
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import apm_pkg::*;
  logic clk_in, rst_in, cs_n, sclk, din, shutdown_input_n_n, shutdown_input_n_float, dout, dout_oe, strb, strb_oe, dpin;
  logic [7:0] code;
  logic [15:0] v;
  apm_status_t status;
  int errors, checked;
  logic [7:0] ctrls [3] = '{8'h82, 8'h80, 8'h82};
  logic [7:0] codes [3] = '{8'ha5, 8'h3c, 8'h5a};
  logic pw [3] = '{1'b1, 1'b0, 1'b1};
  assign dpin = dout_oe ? dout : ~dout; // released line never holds
  apm_core #(.CONV_CYCLES(20)) apm_core_inst (.clk_in(clk_in), .rst_in(rst_in), .cs_n_in(cs_n),
    .sclk_in(sclk), .din_in(din), .shutdown_input_n_in(shutdown_input_n_n), .shutdown_float_in(shutdown_input_n_float),
    .conversion_code_in(code), .dout_out(dout), .dout_oe_out(dout_oe),
    .conversion_done_strobe_out(strb), .conversion_done_strobe_oe_out(strb_oe), .status_out(status));
  apm_host apm_host_inst (.cs_n_out(cs_n), .sclk_out(sclk), .din_out(din), .dout_in(dpin));
  initial
  begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic clk(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic ctl(input logic [7:0] b);
    logic [7:0] r;
    apm_host_inst.sel(1'b1);
    apm_host_inst.xfer(b, r);
    apm_host_inst.sel(1'b0);
    clk(1);
  endtask
  task automatic rd(output logic [15:0] w);
    apm_host_inst.sel(1'b1);
    apm_host_inst.xfer(8'h00, w[15:8]);
    apm_host_inst.xfer(8'h00, w[7:0]);
    apm_host_inst.sel(1'b0);
  endtask
  task automatic end_sim;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // watchdog
  initial
  begin
    #100000;
    errors++;
    end_sim();
  end
  initial
  begin
    rst_in = 1'b1;
    shutdown_input_n_n = 1'b1;
    shutdown_input_n_float = 1'b0;
    code = 8'h00;
    repeat (20) @(posedge clk_in);
    #1 rst_in = 1'b0;
    clk(6);
    chk("powered", 1, status.powered);
    chk("strobe", 1, strb);
    chk("strobe_oe", 1, strb_oe);
    rd(v);
    chk("early_data", 0, v);
    $display("power-up test done");
    for (int i = 0; i < 3; i++)
    begin
      code = codes[i];
      ctl(ctrls[i]);
      chk("awake", 1, status.powered);
      chk("strobe_low", 0, strb);
      for (int n = 0; n < 400 && strb !== 1'b1; n++)
        clk(1);
      clk(2);
      chk("powered", pw[i], status.powered);
      rd(v);
      chk("result", {2'b00, codes[i], 6'h00}, v);
      $display("conversion test %0d done", i);
    end
    code = 8'h77;
    ctl(8'h82);
    clk(1);
    chk("busy", 1, status.converting);
    shutdown_input_n_n = 1'b0;
    clk(6);
    chk("off", 0, status);
    ctl(8'h82);
    clk(2);
    chk("stay_off", 0, status.powered);
    shutdown_input_n_n = 1'b1;
    shutdown_input_n_float = 1'b1;
    clk(6);
    chk("ref_on", 3, status[3:2]);
    shutdown_input_n_float = 1'b0;
    clk(6);
    chk("ref_off", 2, status[3:2]);
    $display("shutdown test done");
    ctl(8'h83);
    clk(6);
    chk("ext_abort", 0, status.converting);
    chk("ext_oe", 0, strb_oe);
    $display("clock mode test done");
    end_sim();
  end
endmodule
